// ---- shared/spcmd_pkg.sv ----
package spcmd_pkg;

    // Command opcodes
    localparam logic [7:0] OP_SET_MODE    = 8'h2f;
    localparam logic [7:0] OP_SELECT_VOC  = 8'h20;
    localparam logic [7:0] OP_PLAY_WORDS  = 8'h21;
    localparam logic [7:0] OP_TUNE        = 8'h15;

    // Speakerphone mode codes
    localparam logic [7:0] MODE_OFF       = 8'h00;
    localparam logic [7:0] MODE_ON        = 8'h01;
    localparam logic [7:0] MODE_TRANSP    = 8'h02;
    localparam logic [7:0] MODE_MUTE      = 8'h03;
    localparam logic [7:0] MODE_LISTEN    = 8'h04;
    localparam logic [7:0] MODE_RESERVED  = 8'h05;
    localparam logic [7:0] MODE_RESTART   = 8'h06;
    localparam logic [7:0] MODE_HOLD      = 8'h07;
    localparam logic [7:0] MODE_SILENCE   = 8'h08;

    // Vocabulary types
    localparam logic [7:0] VOC_COMPAT     = 8'h00;
    localparam logic [7:0] VOC_ROM        = 8'h01;
    localparam logic [7:0] VOC_FLASH      = 8'h02;

    localparam int         MAX_WORDS      = 8;
    localparam logic [7:0] MAX_WORDS_B    = 8'h08;

    // Tunable parameter table
    localparam int         TUNE_COUNT     = 6;
    localparam logic [7:0] TUNE_IDX [TUNE_COUNT] = '{8'd70, 8'd86, 8'd87, 8'd85, 8'd11, 8'd88};
    localparam logic [15:0] TUNE_DEF [TUNE_COUNT] = '{16'h0001, 16'h0004, 16'h0800,
                                                     16'h0200, 16'h0800, 16'h0002};

    // Vocabulary table headers, ids and word counts
    localparam int         VOC_TABLES     = 4;
    localparam logic [7:0] VOC_ID   [VOC_TABLES] = '{8'h01, 8'h02, 8'h03, 8'h04};
    localparam logic [7:0] VOC_NWORD [VOC_TABLES] = '{8'h40, 8'h40, 8'h80, 8'h20};
    localparam logic [7:0] CTRL_CODE_MIN  = 8'hf0;

    // Playback time per word, and cycles at 100 MHz
    localparam int         WORD_TIME_US   = 2;
    localparam int         CLK_MHZ        = 100;
    localparam int         WORD_CYCLES    = WORD_TIME_US * CLK_MHZ;

    // Status and error word bits
    localparam int         STAT_DONE_BIT  = 0;
    localparam int         BAD_ARGUMENT_ERROR_BIT  = 0;
    localparam int         ERR_STATE_BIT  = 1;

    // APB register offsets
    localparam logic [11:0] REG_STATUS    = 12'h000;
    localparam logic [11:0] REG_ERROR     = 12'h004;
    localparam logic [11:0] REG_MODE      = 12'h008;
    localparam logic [11:0] REG_VOCAB     = 12'h00c;
    localparam logic [11:0] REG_TUNE_SEL  = 12'h010;
    localparam logic [11:0] REG_TUNE_VAL  = 12'h014;

    typedef enum logic [1:0] {
        SPCMD_IDLE,
        SPCMD_SYNTH,
        SPCMD_HANDSFREE
    } spcmd_state_type;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } spcmd_apb_req_type;

    typedef struct packed {
        logic       valid;
        logic [1:0] kind;
        logic [7:0] id;
    } spcmd_vocab_type;

endpackage : spcmd_pkg

// ---- design/spcmd_core.sv ----
// Notes on behaviour
// (R01) Opcode 2f plus one mode byte sets the speakerphone mode.
// (R02) Mode command is taken only in the idle state; the code also takes it in handsfree, refusing it only during synthesis.
// (R03) Mode 0 turns the speakerphone off, back to normal operation.
// (R04) Mode 1: full duplex, both echoes cancelled, tone detectors off.
// (R05) Mode 2 bypasses echo cancelling; mode 5 is reserved.
// (R06) Mode 3 sends silence to the line, tone detectors off.
// (R07) Mode 4 plays the line on the speaker, tone detectors on.
// (R08) Mode 6 restarts the current mode without full initialisation.
// (R09) Mode 7 stops codec interrupts.
// (R10) Mode 8 disables speakerphone, line echo cancelling stays on.
// (R11) In any mode but 0 only a subset of commands is accepted.
// (R12) Vocabulary select: type and id bytes; 0 compat, 1 rom, 2 flash.
// (R13) For types 1 and 2 the table headers are scanned for the id.
// (R14) An unknown vocabulary id sets the parameter error bit.
// (R15) Host selects a vocabulary before any playback command.
// (R16) Opcode 21, count then indices; enters synthesis, plays in order.
// (R17) On completion set done bit, pull request low, return idle.
// (R18) Count over 8 or a bad or control index is a parameter error.
// (R19) Playback with no vocabulary reports an invalid state error.
// (R20) Tune stores a two byte value in the indexed parameter.
// (R21) Bad tune index sets parameter error, parameters unchanged.
// (R22) Parameters take defaults at power up only.
// (R23) Tune opcode 15, then index, value high byte, value low byte.
// (R24) Each received byte is echoed back in the same exchange; the code echoes it in the next byte slot.
// (R25) A rejected command changes no state, vocabulary or parameter.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps

module spcmd_core
    import spcmd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk,
    input  wire logic        link_cs_n,
    input  wire logic        link_din,
    output logic             link_dout,
    output logic             host_request_n,
    output logic             echo_cancel_acoustic,
    output logic             echo_cancel_line,
    output logic             tone_detect_en,
    output logic             line_silence,
    output logic             codec_halt,
    output logic             spk_restart
);

    logic [2:0]      clk_sync;
    logic [1:0]      cs_sync;
    logic [1:0]      din_sync;
    logic [7:0]      shift_in;
    logic [7:0]      shift_out;
    logic [2:0]      bit_cnt;
    logic [7:0]      cmd_buf [12];
    logic [3:0]      byte_cnt;
    logic            byte_strobe;
    spcmd_state_type state;
    logic [7:0]      mode;
    spcmd_vocab_type vocab;
    logic [15:0]     tune_val [TUNE_COUNT];
    logic            done_ev;
    logic [1:0]      err;
    logic [7:0]      word_list [MAX_WORDS];
    logic [3:0]      words_left;
    logic [3:0]      word_pos;
    logic [15:0]     word_timer;
    logic [7:0]      tune_sel;
    logic            cmd_exec;

    wire rise = clk_sync[1] & ~clk_sync[2];
    wire fall = ~clk_sync[1] & clk_sync[2];
    wire cs_act = ~cs_sync[1];
    wire [7:0] rx_byte = {shift_in[6:0], din_sync[1]};
    wire [7:0] op = cmd_buf[0];

    // Byte being stored this cycle is seen before it lands in the buffer
    wire [7:0] op_now  = (byte_cnt == 4'd0) ? shift_in : cmd_buf[0];
    wire [7:0] cnt_now = (byte_cnt == 4'd1) ? shift_in : cmd_buf[1];
    // Expected length of the current command
    wire [3:0] need = (op_now == OP_SET_MODE)   ? 4'd2 :
                      (op_now == OP_SELECT_VOC) ? 4'd3 :
                      (op_now == OP_TUNE)       ? 4'd4 :
                      (op_now == OP_PLAY_WORDS) ? ((cnt_now > MAX_WORDS_B) ? 4'd2
                                                   : 4'(cnt_now[3:0] + 4'd2)) : 4'd1;
    wire cmd_full = byte_strobe & (byte_cnt + 4'd1 >= need) & (byte_cnt != 4'd0 | need == 4'd1);

    // (R13) Header scan for id
    logic       voc_hit;
    logic [7:0] voc_words;
    always_comb begin
        voc_hit   = 1'b0;
        voc_words = 8'h00;
        for (int i = 0; i < VOC_TABLES; i++) begin
            if (VOC_ID[i] == cmd_buf[2]) begin
                voc_hit   = 1'b1;
                voc_words = VOC_NWORD[i];
            end
        end
    end

    logic       tune_hit;
    logic [2:0] tune_slot;
    always_comb begin
        tune_hit  = 1'b0;
        tune_slot = 3'd0;
        for (int i = 0; i < TUNE_COUNT; i++) begin
            if (TUNE_IDX[i] == cmd_buf[1]) begin
                tune_hit  = 1'b1;
                tune_slot = 3'(i);
            end
        end
    end

    // (R18) Index check against current vocabulary
    logic       words_ok;
    logic [7:0] cur_nwords;
    always_comb begin
        cur_nwords = 8'h00;
        for (int i = 0; i < VOC_TABLES; i++) begin
            if (VOC_ID[i] == vocab.id) begin
                cur_nwords = VOC_NWORD[i];
            end
        end
        words_ok = (cmd_buf[1] <= MAX_WORDS_B);
        for (int i = 0; i < MAX_WORDS; i++) begin
            if (4'(i) < cmd_buf[1][3:0] &&
                (cmd_buf[i+2] >= cur_nwords || cmd_buf[i+2] >= CTRL_CODE_MIN)) begin
                words_ok = 1'b0;
            end
        end
    end

    // (R11) Subset accepted while a handsfree mode runs
    wire hf_busy = (mode != MODE_OFF);
    wire allowed = ~hf_busy | (op == OP_SET_MODE) | (op == OP_TUNE);

    wire mode_legal = (cmd_buf[1] <= MODE_SILENCE) & (cmd_buf[1] != MODE_RESERVED);
    wire voc_type_ok = (cmd_buf[1] <= VOC_FLASH);
    wire voc_needs_scan = (cmd_buf[1] == VOC_ROM) | (cmd_buf[1] == VOC_FLASH);

    // (R02) Mode command only from idle or handsfree, never during synthesis
    wire do_mode = cmd_exec & (op == OP_SET_MODE) & (state != SPCMD_SYNTH) & mode_legal;
    wire do_voc  = cmd_exec & (op == OP_SELECT_VOC) & allowed & (state == SPCMD_IDLE)
                   & voc_type_ok & (~voc_needs_scan | voc_hit);
    wire do_tune = cmd_exec & (op == OP_TUNE) & tune_hit;
    wire do_play = cmd_exec & (op == OP_PLAY_WORDS) & allowed & (state == SPCMD_IDLE)
                   & vocab.valid & words_ok;
    // (R14) (R18) (R21) Parameter errors
    wire bad_param = cmd_exec & (((op == OP_SET_MODE) & ~mode_legal)
                   | ((op == OP_SELECT_VOC) & allowed & (~voc_type_ok | (voc_needs_scan & ~voc_hit)))
                   | ((op == OP_TUNE) & ~tune_hit)
                   | ((op == OP_PLAY_WORDS) & allowed & vocab.valid & ~words_ok));
    // (R19) Invalid state errors
    wire bad_state = cmd_exec & ((op == OP_PLAY_WORDS) & allowed & ~vocab.valid
                   | (op == OP_SET_MODE) & (state == SPCMD_SYNTH));

    wire word_end  = (state == SPCMD_SYNTH) & (word_timer == 16'd1);
    wire play_end  = word_end & (words_left == 4'd1);
    wire [7:0] cur_word = word_list[word_pos[2:0]];

    wire sel_status = (paddr == REG_STATUS);
    wire sel_error  = (paddr == REG_ERROR);
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & ~penable & ~pwrite;
    wire mapped = (paddr == REG_STATUS) | (paddr == REG_ERROR) | (paddr == REG_MODE)
                | (paddr == REG_VOCAB) | (paddr == REG_TUNE_SEL) | (paddr == REG_TUNE_VAL);
    wire [2:0] rd_slot = (tune_sel < 8'(TUNE_COUNT)) ? tune_sel[2:0] : 3'd0;
    wire [31:0] rd_mux = (paddr == REG_STATUS)   ? {30'h0, state == SPCMD_SYNTH, done_ev} :
                         (paddr == REG_ERROR)    ? {30'h0, err} :
                         (paddr == REG_MODE)     ? {24'h0, mode} :
                         (paddr == REG_VOCAB)    ? {21'h0, vocab.valid, vocab.kind, vocab.id} :
                         (paddr == REG_TUNE_SEL) ? {24'h0, tune_sel} :
                         (paddr == REG_TUNE_VAL) ? {16'h0, tune_val[rd_slot]} : 32'h0;

    // Link sampling and shifting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync    <= 3'h0;
            cs_sync     <= 2'h3;
            din_sync    <= 2'h0;
            shift_in    <= 8'h00;
            bit_cnt     <= 3'd0;
            byte_strobe <= 1'b0;
            byte_cnt    <= 4'd0;
            cmd_exec    <= 1'b0;
        end else begin
            clk_sync    <= {clk_sync[1:0], link_clk};
            cs_sync     <= {cs_sync[0], link_cs_n};
            din_sync    <= {din_sync[0], link_din};
            byte_strobe <= 1'b0;
            if (!cs_act) begin
                bit_cnt <= 3'd0;
            end else if (rise) begin
                shift_in <= rx_byte;
                bit_cnt  <= bit_cnt + 3'd1;
                byte_strobe <= (bit_cnt == 3'd7);
            end
            // Execute one cycle later, once the last byte is in the buffer
            cmd_exec <= cmd_full;
            if (cmd_full) begin
                byte_cnt <= 4'd0;
            end else if (!cs_act) begin
                byte_cnt <= 4'd0;
            end else if (byte_strobe) begin
                byte_cnt <= byte_cnt + 4'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 12; i++) begin
                cmd_buf[i] <= 8'h00;
            end
        end else if (byte_strobe) begin
            cmd_buf[byte_cnt] <= shift_in;
        end
    end

    // (R24) Echo each received byte back on the next byte slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_out <= 8'h00;
            link_dout <= 1'b0;
        end else if (byte_strobe) begin
            shift_out <= shift_in;
            link_dout <= shift_in[7];
        end else if (cs_act & fall & (bit_cnt != 3'd0)) begin
            shift_out <= {shift_out[6:0], 1'b0};
            link_dout <= shift_out[6];
        end
    end

    // (R16) (R17) (R25) Command execution and state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= SPCMD_IDLE;
            mode           <= MODE_OFF;
            vocab          <= '0;
            words_left     <= 4'd0;
            word_pos       <= 4'd0;
            word_timer     <= 16'd0;
            host_request_n <= 1'b1;
        end else begin
            // (R01) Mode change
            if (do_mode) begin
                if (cmd_buf[1] != MODE_RESTART) begin
                    mode <= cmd_buf[1];
                end
                state <= (cmd_buf[1] == MODE_OFF || (cmd_buf[1] == MODE_RESTART && mode == MODE_OFF))
                         ? SPCMD_IDLE : SPCMD_HANDSFREE;
            end
            // (R12) Vocabulary select
            if (do_voc) begin
                vocab.valid <= 1'b1;
                vocab.kind  <= cmd_buf[1][1:0];
                vocab.id    <= cmd_buf[2];
            end
            if (do_play) begin
                state          <= SPCMD_SYNTH;
                words_left     <= cmd_buf[1][3:0];
                word_pos       <= 4'd0;
                word_timer     <= 16'(WORD_CYCLES);
                host_request_n <= 1'b1;
                if (cmd_buf[1] == 8'h00) begin
                    words_left <= 4'd1;
                end
            end else if (word_end) begin
                word_pos   <= word_pos + 4'd1;
                words_left <= words_left - 4'd1;
                word_timer <= 16'(WORD_CYCLES);
                // (R17) Completion
                if (play_end) begin
                    state          <= SPCMD_IDLE;
                    host_request_n <= 1'b0;
                end
            end else if (state == SPCMD_SYNTH) begin
                word_timer <= word_timer - 16'd1;
            end else if (byte_strobe) begin
                host_request_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (do_play) begin
            for (int i = 0; i < MAX_WORDS; i++) begin
                word_list[i] <= cmd_buf[i+2];
            end
        end
    end

    // (R20) (R22) Tunable storage, defaults at reset only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < TUNE_COUNT; i++) begin
                tune_val[i] <= TUNE_DEF[i];
            end
        end else if (do_tune) begin
            // (R23) High byte then low byte
            tune_val[tune_slot] <= {cmd_buf[2], cmd_buf[3]};
        end
    end

    // Status and error words, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ev  <= 1'b0;
            err      <= 2'b00;
            tune_sel <= 8'h00;
        end else begin
            done_ev <= play_end | (done_ev & ~(apb_wr & sel_status & pwdata[STAT_DONE_BIT]));
            err[BAD_ARGUMENT_ERROR_BIT] <= bad_param
                | (err[BAD_ARGUMENT_ERROR_BIT] & ~(apb_wr & sel_error & pwdata[BAD_ARGUMENT_ERROR_BIT]));
            err[ERR_STATE_BIT] <= bad_state
                | (err[ERR_STATE_BIT] & ~(apb_wr & sel_error & pwdata[ERR_STATE_BIT]));
            if (apb_wr & (paddr == REG_TUNE_SEL)) begin
                tune_sel <= pwdata[7:0];
            end
        end
    end

    // Mode decode for the audio path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_cancel_acoustic <= 1'b0;
            echo_cancel_line     <= 1'b0;
            tone_detect_en       <= 1'b0;
            line_silence         <= 1'b0;
            codec_halt           <= 1'b0;
            spk_restart          <= 1'b0;
        end else begin
            // (R03) (R04) (R05) (R06) Echo and tone settings
            echo_cancel_acoustic <= (mode == MODE_ON) | (mode == MODE_MUTE);
            // (R10) Line echo kept in silence mode
            echo_cancel_line     <= (mode == MODE_ON) | (mode == MODE_MUTE)
                                  | (mode == MODE_SILENCE);
            // (R07) Listen enables tone detectors
            tone_detect_en       <= (mode == MODE_LISTEN);
            line_silence         <= (mode == MODE_MUTE);
            // (R09) Hold stops codec
            codec_halt           <= (mode == MODE_HOLD);
            // (R08) Restart pulse
            spk_restart          <= do_mode & (cmd_buf[1] == MODE_RESTART);
        end
    end

    // APB slave, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (apb_rd) begin
                prdata <= rd_mux;
            end
        end
    end

endmodule : spcmd_core

// ---- dv/spcmd_core_checker.sv ----
`timescale 1ns/10ps

module spcmd_core_checker
    import spcmd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_cs_n,
    input wire logic host_request_n,
    input wire logic echo_cancel_acoustic,
    input wire logic echo_cancel_line,
    input wire logic tone_detect_en,
    input wire logic line_silence,
    input wire logic codec_halt,
    input wire logic spk_restart
);
    localparam int MIN_PLAY = WORD_CYCLES - 20;
    logic [8:0] quiet_cnt;
    logic [8:0] next_quiet_cnt;

    // Cycles since the link was last selected
    assign next_quiet_cnt = (!link_cs_n) ? 9'h000 :
                            (quiet_cnt == 9'h1ff) ? quiet_cnt : quiet_cnt + 9'h001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_cnt <= 9'h000;
        else quiet_cnt <= next_quiet_cnt;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_mode_off: assert property ($rose(presetn) |-> host_request_n &&
        !echo_cancel_acoustic && !echo_cancel_line && !tone_detect_en && !codec_halt)
        else $error("outputs not idle after reset");
    chk_full_duplex_line: assert property (echo_cancel_acoustic |-> echo_cancel_line)
        else $error("acoustic cancel without line cancel");
    chk_duplex_no_tones: assert property (echo_cancel_acoustic |-> !tone_detect_en)
        else $error("tone detect on in full duplex");
    chk_mute_no_tones: assert property (line_silence |-> !tone_detect_en)
        else $error("tone detect on while muted");
    chk_hold_no_mute: assert property (codec_halt |-> !line_silence)
        else $error("hold and mute together");
    chk_restart_pulse: assert property (spk_restart |=> !spk_restart)
        else $error("restart pulse too long");
    chk_restart_keeps_mode: assert property (spk_restart |=> $stable({echo_cancel_acoustic,
        echo_cancel_line, tone_detect_en, line_silence, codec_halt}))
        else $error("restart changed the mode");
    chk_done_after_play: assert property ($fell(host_request_n) |-> quiet_cnt >= MIN_PLAY)
        else $error("request low before a word could play");
    chk_request_holds: assert property (!host_request_n && quiet_cnt > 9'd10
        |=> !host_request_n)
        else $error("request released without link traffic");
endmodule : spcmd_core_checker

bind spcmd_core spcmd_core_checker chk (.pclk(pclk), .presetn(presetn), .link_cs_n(link_cs_n),
    .host_request_n(host_request_n), .echo_cancel_acoustic(echo_cancel_acoustic),
    .echo_cancel_line(echo_cancel_line), .tone_detect_en(tone_detect_en),
    .line_silence(line_silence), .codec_halt(codec_halt), .spk_restart(spk_restart));

// ---- dv/spcmd_host_model.sv ----
`timescale 1ns/10ps

module spcmd_host_model (
    output logic     link_clk,
    output logic     link_cs_n,
    output logic     link_din,
    input wire logic link_dout
);
    initial begin
        link_clk = 1'b0;
        link_cs_n = 1'b1;
        link_din = 1'b1;
    end

    // opcode first, MSB first, 80 ns bit period
    task send(input logic [7:0] b[$], output logic [7:0] e[$]);
        logic [7:0] sh;
        e = {};
        sh = 8'h00;
        #13 link_cs_n = 1'b0;
        foreach (b[k]) begin
            for (int i = 7; i >= 0; i--) begin
                #20 link_din = b[k][i];
                #20 link_clk = 1'b1;
                sh = {sh[6:0], link_dout};
                #40 link_clk = 1'b0;
            end
            e.push_back(sh);
        end
        #40 link_cs_n = 1'b1;
        link_din = ~link_din;
    endtask : send
endmodule : spcmd_host_model

// ---- dv/spcmd_core_test.sv ----
`timescale 1ns/10ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR t=%0t got %h expected %h", $time, got, exp); end end

module spcmd_core_test;
    import spcmd_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, link_clk, link_cs_n, link_din, link_dout, host_request_n;
    logic [4:0]  outs;
    logic        restart;
    logic [7:0]  echo[$];
    int          mismatches = 0;
    int          checks = 0;
    int          restarts = 0;
    localparam logic [7:0] MSEQ[9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h05, 8'h00};
    localparam logic [7:0] MREG[9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h07, 8'h08, 8'h08, 8'h00};
    localparam logic [4:0] MASK[9] = '{5'h1c, 5'h18, 5'h06, 5'h04, 5'h04, 5'h01, 5'h08, 5'h08, 5'h1f};
    localparam logic [4:0] MVAL[9] = '{5'h18, 5'h00, 5'h02, 5'h04, 5'h04, 5'h01, 5'h08, 5'h08, 5'h00};

    always #5 pclk = ~pclk;
    always @(posedge pclk) if (restart === 1'b1) restarts++;

    spcmd_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .link_cs_n(link_cs_n), .link_din(link_din),
        .link_dout(link_dout), .host_request_n(host_request_n),
        .echo_cancel_acoustic(outs[4]), .echo_cancel_line(outs[3]), .tone_detect_en(outs[2]),
        .line_silence(outs[1]), .codec_halt(outs[0]), .spk_restart(restart));
    spcmd_host_model host (.link_clk(link_clk), .link_cs_n(link_cs_n), .link_din(link_din),
        .link_dout(link_dout));

    task print_verdict;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (n >= 16) begin
            mismatches++;
            $display("ERROR t=%0t bus timeout", $time);
            print_verdict();
        end
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHECK(rd, exp)
    endtask : rdchk

    task cmd(input logic [7:0] b[$]);
        @(posedge pclk);
        host.send(b, echo);
        foreach (echo[k]) if (k > 0) `CHECK(echo[k], b[k-1])
        repeat (3) @(posedge pclk);
    endtask : cmd

    task wait_done;
        int n;
        n = 0;
        while (host_request_n !== 1'b0 && n < 3000) begin @(posedge pclk); n++; end
        if (n >= 3000) begin mismatches++; $display("ERROR t=%0t no done", $time); end
    endtask : wait_done

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < TUNE_COUNT; i++) begin
            apb(1'b1, REG_TUNE_SEL, i);
            rdchk(REG_TUNE_VAL, {16'h0, TUNE_DEF[i]});
        end
        rdchk(REG_MODE, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        `CHECK({err, rd}, 33'h1_0000_0000)
        cmd('{OP_PLAY_WORDS, 8'h01, 8'h00});
        rdchk(REG_ERROR, 32'h2);
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_SELECT_VOC, VOC_FLASH, 8'h03});
        rdchk(REG_VOCAB, 32'h603);
        cmd('{OP_SELECT_VOC, VOC_ROM, 8'h09});
        rdchk(REG_ERROR, 32'h1);
        rdchk(REG_VOCAB, 32'h603);
        // count, control code and undefined index
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_PLAY_WORDS, 8'h09});
        rdchk(REG_ERROR, 32'h1);
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_PLAY_WORDS, 8'h01, 8'hf0});
        rdchk(REG_ERROR, 32'h1);
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_PLAY_WORDS, 8'h02, 8'h7f, 8'h80});
        rdchk(REG_ERROR, 32'h1);
        rdchk(REG_STATUS, 32'h0);
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_PLAY_WORDS, 8'h02, 8'h00, 8'h7f});
        rdchk(REG_STATUS, 32'h2);
        cmd('{OP_SET_MODE, MODE_ON});
        rdchk(REG_ERROR, 32'h2);
        rdchk(REG_MODE, 32'h0);
        wait_done();
        `CHECK(host_request_n, 1'b0)
        rdchk(REG_STATUS, 32'h1);
        apb(1'b1, REG_STATUS, 32'h1);
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_TUNE, 8'h46, 8'h12, 8'h34});
        apb(1'b1, REG_TUNE_SEL, 32'h0);
        rdchk(REG_TUNE_VAL, 32'h1234);
        cmd('{OP_TUNE, 8'h01, 8'hab, 8'hcd});
        rdchk(REG_ERROR, 32'h1);
        rdchk(REG_TUNE_VAL, 32'h1234);
        apb(1'b1, REG_ERROR, 32'h3);
        cmd('{OP_SET_MODE, MODE_ON});
        cmd('{OP_SELECT_VOC, VOC_ROM, 8'h01});
        rdchk(REG_VOCAB, 32'h603);
        rdchk(REG_ERROR, 32'h0);
        for (int i = 0; i < 9; i++) begin
            cmd('{OP_SET_MODE, MSEQ[i]});
            rdchk(REG_MODE, {24'h0, MREG[i]});
            `CHECK(outs & MASK[i], MVAL[i])
        end
        rdchk(REG_ERROR, 32'h1);
        `CHECK(restarts, 1)
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        $display("ERROR t=%0t run timeout", $time);
        print_verdict();
    end
endmodule : spcmd_core_test
